// *** verilog/lcdsm_top.sv ***
// lcdsm_top: display memory scan sequencer with buffered host access
`timescale 1ns/10ps
`default_nettype none
module lcdsm_top
  import lcdsm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // display memory
  output lcdsm_vram_t vram_o,
  input wire logic [7:0] vram_rdata_i,
  // lcd drive and scan stream
  output lcdsm_lcd_t lcd_o,
  output lcdsm_scan_t scan_o,
  output logic retrace_flag_bit
);
  // ---------------------------------------------------------------
  // state and helpers
  // ---------------------------------------------------------------
  lcdsm_state_t st_r;
  lcdsm_state_t st_nxt;
  logic acc;
  logic retrace;
  logic [15:0] step_ext;
  logic [15:0] scan_addr;

  // retrace once the span passes the char count
  assign retrace = st_r.char_cnt > st_r.cr;
  assign step_ext = {{8{st_r.step[7]}}, st_r.step};
  // column offset on the current line start of the active panel
  assign scan_addr = (st_r.panel ? st_r.ls_lo : st_r.ls_up)
                     + {8'h00, st_r.char_cnt};
  assign acc = wb_cyc_i && wb_stb_i && !st_r.ack;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    // pin input synchroniser, second stage is the only reader
    st_nxt.sync1 = vram_rdata_i;
    st_nxt.sync2 = st_r.sync1;
    // host port and configuration
    if (acc) begin
      st_nxt.ack = 1'b1;
      st_nxt.dat = '0;
      if (wb_adr_i == ADR_PORT_DATA) begin
        if (!wb_we_i) begin
          st_nxt.dat[STATUS_BIT] = retrace;
        end else if (st_r.pend) begin
          st_nxt.ack = 1'b0; // stall until the buffered byte lands
        end else if (wb_sel_i[0]) begin
          case (st_r.hst)
            HST_WRITE: begin
              st_nxt.wbuf = wb_dat_i[7:0];
              st_nxt.pend = 1'b1;
              st_nxt.pend_rd = 1'b0;
            end
            HST_CSR_LO: begin
              st_nxt.cursor[7:0] = wb_dat_i[7:0];
              st_nxt.hst = HST_CSR_HI;
            end
            HST_CSR_HI: begin
              st_nxt.cursor[15:8] = wb_dat_i[7:0];
              st_nxt.hst = HST_IDLE;
            end
            HST_STEP: begin
              st_nxt.step = wb_dat_i[7:0];
              st_nxt.hst = HST_IDLE;
            end
            default: begin
            end
          endcase
        end
      end else if (wb_adr_i == ADR_PORT_CMD) begin
        if (st_r.pend) begin
          st_nxt.ack = 1'b0; // one host access in flight at most
        end else if (wb_we_i && wb_sel_i[0]) begin
          // command decode; a write stream needs no repeat
          case (wb_dat_i[7:0])
            CMD_MEM_WRITE: st_nxt.hst = HST_WRITE;
            CMD_MEM_READ: begin
              st_nxt.hst = HST_READ;
              st_nxt.pend = 1'b1; // preload the output buffer
              st_nxt.pend_rd = 1'b1;
            end
            CMD_CURSOR_SET: st_nxt.hst = HST_CSR_LO;
            CMD_CURSOR_STEP: st_nxt.hst = HST_STEP;
            default: st_nxt.hst = HST_IDLE;
          endcase
        end else if (!wb_we_i) begin
          if (st_r.hst == HST_READ) begin
            st_nxt.dat[7:0] = st_r.rbuf;
            st_nxt.pend = 1'b1; // fetch next for the following read
            st_nxt.pend_rd = 1'b1;
          end else begin
            st_nxt.dat[15:0] = st_r.cursor;
          end
        end
      end else if (wb_adr_i == ADR_CHAR_CNT) begin
        st_nxt.dat[7:0] = st_r.cr;
        if (wb_we_i && wb_sel_i[0]) st_nxt.cr = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_TOTAL_CNT) begin
        st_nxt.dat[7:0] = st_r.tcr;
        if (wb_we_i && wb_sel_i[0]) st_nxt.tcr = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_PITCH) begin
        st_nxt.dat[7:0] = st_r.pitch;
        if (wb_we_i && wb_sel_i[0]) st_nxt.pitch = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_LINES) begin
        st_nxt.dat[7:0] = st_r.lines;
        if (wb_we_i && wb_sel_i[0]) st_nxt.lines = wb_dat_i[7:0];
      end else if (wb_adr_i == ADR_START_UP) begin
        st_nxt.dat[15:0] = st_r.sad_up;
        if (wb_we_i && wb_sel_i[0]) st_nxt.sad_up[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) st_nxt.sad_up[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == ADR_START_LO) begin
        st_nxt.dat[15:0] = st_r.sad_lo;
        if (wb_we_i && wb_sel_i[0]) st_nxt.sad_lo[7:0] = wb_dat_i[7:0];
        if (wb_we_i && wb_sel_i[1]) st_nxt.sad_lo[15:8] = wb_dat_i[15:8];
      end else if (wb_adr_i == ADR_MODE) begin
        st_nxt.dat[MODE_GFX_BIT] = st_r.graphics;
        st_nxt.dat[MODE_DUAL_BIT] = st_r.dual;
        st_nxt.dat[MODE_FY_LSB +: 4] = st_r.fy;
        st_nxt.dat[MODE_FX_LSB +: 4] = st_r.fx;
        if (wb_we_i && wb_sel_i[0]) begin
          st_nxt.graphics = wb_dat_i[MODE_GFX_BIT];
          st_nxt.dual = wb_dat_i[MODE_DUAL_BIT];
          st_nxt.fy = wb_dat_i[MODE_FY_LSB +: 4];
        end
        if (wb_we_i && wb_sel_i[1]) st_nxt.fx = wb_dat_i[MODE_FX_LSB +: 4];
      end
    end
    // nine-clock read cycle
    st_nxt.phase = (st_r.phase == PHASE_LAST) ? 4'h0 : st_r.phase + 4'h1;
    st_nxt.lcd.shift_clock_out = st_nxt.phase < PH_SHIFT_LOW;
    // memory address, data and output enable move only on three-clock slot boundaries; the write strobe falls one clock later
    if (st_r.phase == PH_SCAN_ADDR) begin
      st_nxt.vram.oe_n = retrace;
      st_nxt.vram.we_n = 1'b1;
      if (!retrace) st_nxt.vram.addr = scan_addr;
    end
    // scan byte sampled before the host slot takes the bus
    st_nxt.scan.valid = 1'b0;
    if (st_r.phase == PH_SCAN_TAKE && !st_r.vram.oe_n) begin
      st_nxt.scan.valid = 1'b1;
      st_nxt.scan.data = st_r.sync2; // text: char code; gfx: 8 pixels
      st_nxt.scan.row = st_r.row;
      st_nxt.scan.lower = st_r.panel;
      st_nxt.scan.graphics = st_r.graphics;
      st_nxt.scan.two_bytes = !st_r.graphics
                              && st_r.fx > FX_ONE_BYTE;
    end
    // host slot in the second third of every cycle
    if (st_r.phase == PH_HOST_ADDR) begin
      st_nxt.vram.oe_n = 1'b1;
      if (st_r.pend) begin
        st_nxt.slot = 1'b1;
        st_nxt.vram.addr = st_r.cursor;
        st_nxt.vram.wdata = st_r.wbuf;
        st_nxt.vram.oe_n = !st_r.pend_rd;
      end
    end
    if (st_r.phase == PH_HOST_WE) begin
      st_nxt.vram.we_n = !(st_r.slot && !st_r.pend_rd);
    end
    if (st_r.phase == PH_HOST_DONE) begin
      st_nxt.vram.we_n = 1'b1;
      st_nxt.vram.oe_n = 1'b1;
      if (st_r.slot) begin
        if (st_r.pend_rd) st_nxt.rbuf = st_r.sync2;
        st_nxt.cursor = st_r.cursor + step_ext;
        st_nxt.slot = 1'b0;
        st_nxt.pend = 1'b0;
      end
    end
    // line and frame sequencing at the end of each read cycle
    if (st_r.phase == PHASE_LAST) begin
      st_nxt.lcd.line_latch_pulse = 1'b0;
      if (st_r.char_cnt >= st_r.tcr) begin
        st_nxt.char_cnt = 8'h00;
        if (st_r.dual && !st_r.panel) begin
          st_nxt.panel = 1'b1; // lower panel line follows
        end else begin
          st_nxt.panel = 1'b0;
          st_nxt.lcd.line_latch_pulse = 1'b1;
          if (st_r.rline >= st_r.lines) begin
            st_nxt.rline = 8'h00;
            st_nxt.row = 4'h0;
            st_nxt.ls_up = st_r.sad_up;
            st_nxt.ls_lo = st_r.sad_lo;
            st_nxt.lcd.frame_alternation_out =
              !st_r.lcd.frame_alternation_out;
          end else begin
            st_nxt.rline = st_r.rline + 8'h01;
            if (!st_r.graphics && st_r.row < st_r.fy) begin
              st_nxt.row = st_r.row + 4'h1; // same codes again
            end else begin
              // gfx moves every raster line, hence 8x memory
              st_nxt.row = 4'h0;
              st_nxt.ls_up = st_r.ls_up + {8'h00, st_r.pitch};
              st_nxt.ls_lo = st_r.ls_lo + {8'h00, st_r.pitch};
            end
          end
        end
      end else begin
        st_nxt.char_cnt = st_r.char_cnt + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset stops the drive outputs and blocks the host port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops, except retrace_flag_bit, which is a compare of two
  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.dat;
  assign vram_o = st_r.vram;
  assign lcd_o = st_r.lcd;
  assign scan_o = st_r.scan;
  assign retrace_flag_bit = retrace;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_PHASE_WRAP: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_r.phase == PHASE_LAST |=> st_r.phase == 4'h0 ##9 st_r.phase == 4'h0)
    else $error("read cycle is not nine clocks");
  AST_ADDR_THIRD: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(vram_o.addr) |-> (st_r.phase == 4'h1 || st_r.phase == 4'h4))
    else $error("memory address moved off a slot boundary");
  AST_RETRACE_QUIET: assert property (@(posedge core_clk) disable iff (!reset_n)
    (retrace && st_r.phase == 4'h1) |-> vram_o.oe_n [*3])
    else $error("scan read during line end pause");
  AST_STATUS_BIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (acc && !wb_we_i && wb_adr_i == ADR_PORT_DATA)
    |=> wb_ack_o && wb_dat_o[STATUS_BIT] == $past(retrace))
    else $error("status read did not return the retrace flag");
  AST_LATCH_LEN: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(lcd_o.line_latch_pulse) |-> lcd_o.line_latch_pulse [*8]
    ##1 lcd_o.line_latch_pulse ##1 !lcd_o.line_latch_pulse)
    else $error("latch pulse not one read cycle long");
  AST_DUAL_LATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
    ($rose(lcd_o.line_latch_pulse) && st_r.dual) |-> $past(st_r.panel))
    else $error("latch pulse after the upper panel line");
  AST_CURSOR_STEP: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_r.slot && st_r.phase == PH_HOST_DONE)
    |=> st_r.cursor == $past(st_r.cursor) + $past(step_ext))
    else $error("cursor did not advance by the step");
  AST_HOST_BOUND: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(st_r.pend) |-> ##[1:18] !st_r.pend)
    else $error("host access not served within two read cycles");
  AST_WE_SLOT: assert property (@(posedge core_clk) disable iff (!reset_n)
    !vram_o.we_n |-> (st_r.phase == 4'h5 || st_r.phase == 4'h6)
    && $past(vram_o.we_n, 2))
    else $error("write strobe outside the host slot");
  AST_RESET_HALT: assert property (@(posedge core_clk)
    !reset_n |-> lcd_o == '0 && !wb_ack_o)
    else $error("drive outputs active during reset");

  // ---------------------------------------------------------------
  // scan and host path checks
  // ---------------------------------------------------------------
  // scan byte shows one clock after its take phase
  AST_SCAN_PHASE: assert property (@(posedge core_clk)
    disable iff (!reset_n) scan_o.valid |-> st_r.phase == 4'h4)
    else $error("scan byte outside its slot");
  // shift clock falls entering the low five clocks of the cycle
  AST_SHIFT_LOW: assert property (@(posedge core_clk)
    disable iff (!reset_n) st_r.phase == PH_SHIFT_LOW
    |-> !lcd_o.shift_clock_out && $past(lcd_o.shift_clock_out))
    else $error("shift clock not low in the second part");
  // the read command starts the prefetch
  AST_PREFETCH: assert property (@(posedge core_clk)
    disable iff (!reset_n) (acc && wb_we_i && wb_sel_i[0] && !st_r.pend
    && wb_adr_i == ADR_PORT_CMD && wb_dat_i[7:0] == CMD_MEM_READ)
    |=> st_r.pend && st_r.pend_rd)
    else $error("read command did not start a prefetch");
  // a finished host read refills the output buffer
  AST_RBUF_FILL: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_r.slot && st_r.pend_rd
    && st_r.phase == PH_HOST_DONE) |=> st_r.rbuf == $past(st_r.sync2))
    else $error("output buffer not refilled");
  // graphics line start moves by the pitch
  AST_GFX_PITCH: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_r.phase == PHASE_LAST && !st_r.dual
    && st_r.char_cnt >= st_r.tcr && st_r.graphics
    && st_r.rline < st_r.lines)
    |=> st_r.ls_up == $past(st_r.ls_up) + {8'h00, $past(st_r.pitch)})
    else $error("graphics line start did not add the pitch");
  // text rows reuse the start and advance the glyph row
  AST_TEXT_ROW: assert property (@(posedge core_clk)
    disable iff (!reset_n) (st_r.phase == PHASE_LAST && !st_r.dual
    && st_r.char_cnt >= st_r.tcr && !st_r.graphics
    && st_r.rline < st_r.lines && st_r.row < st_r.fy)
    |=> st_r.ls_up == $past(st_r.ls_up)
    && st_r.row == $past(st_r.row) + 4'h1)
    else $error("text row did not reuse the line start");

  COV_LATCH: cover property (@(posedge core_clk) disable iff (!reset_n)
    $rose(lcd_o.line_latch_pulse));
  COV_HOST_READ: cover property (@(posedge core_clk) disable iff (!reset_n)
    st_r.slot && st_r.pend_rd && st_r.phase == PH_HOST_DONE);
  COV_HOST_WRITE: cover property (@(posedge core_clk) disable iff (!reset_n)
    !vram_o.we_n);
  COV_FRAME: cover property (@(posedge core_clk) disable iff (!reset_n)
    $changed(lcd_o.frame_alternation_out));
  COV_DUAL: cover property (@(posedge core_clk) disable iff (!reset_n)
    scan_o.valid && scan_o.lower);
endmodule : lcdsm_top
`default_nettype wire

// *** shared/lcdsm_pkg.sv ***
// lcdsm_pkg: constants, carriers and state layout of the lcd scan block
package lcdsm_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses on the wishbone port)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_PORT_DATA = 8'h00; // select low
  localparam logic [7:0] ADR_PORT_CMD = 8'h04;  // select high
  localparam logic [7:0] ADR_CHAR_CNT = 8'h08;
  localparam logic [7:0] ADR_TOTAL_CNT = 8'h0c;
  localparam logic [7:0] ADR_PITCH = 8'h10;
  localparam logic [7:0] ADR_LINES = 8'h14;
  localparam logic [7:0] ADR_START_UP = 8'h18;
  localparam logic [7:0] ADR_START_LO = 8'h1c;
  localparam logic [7:0] ADR_MODE = 8'h20;
  // mode register fields and the data port status bit
  localparam int MODE_GFX_BIT = 0;
  localparam int MODE_DUAL_BIT = 1;
  localparam int MODE_FY_LSB = 4;
  localparam int MODE_FX_LSB = 8;
  localparam int STATUS_BIT = 6;
  // ---------------------------------------------------------------
  // command codes, read-cycle timing and the one-byte field width
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_MEM_WRITE = 8'h42;
  localparam logic [7:0] CMD_MEM_READ = 8'h43;
  localparam logic [7:0] CMD_CURSOR_SET = 8'h46;
  localparam logic [7:0] CMD_CURSOR_STEP = 8'h4c;
  localparam logic [3:0] PHASE_LAST = 4'h8;   // nine clocks per cycle
  localparam logic [3:0] PH_SCAN_ADDR = 4'h0;
  localparam logic [3:0] PH_SCAN_TAKE = 4'h3;
  localparam logic [3:0] PH_HOST_ADDR = 4'h3;
  localparam logic [3:0] PH_HOST_WE = 4'h4;
  localparam logic [3:0] PH_HOST_DONE = 4'h6;
  localparam logic [3:0] PH_SHIFT_LOW = 4'h4;
  localparam logic [3:0] FX_ONE_BYTE = 4'h7;
  // ---------------------------------------------------------------
  // reset values of the configuration
  // ---------------------------------------------------------------
  localparam logic [7:0] CHAR_CNT_RST = 8'h27;
  localparam logic [7:0] TOTAL_CNT_RST = 8'h2f;
  localparam logic [7:0] PITCH_RST = 8'h28;
  localparam logic [7:0] LINES_RST = 8'hef;
  localparam logic [7:0] STEP_RST = 8'h01;
  localparam logic [3:0] FY_RST = 4'h7;
  localparam logic [3:0] FX_RST = 4'h7;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000, HST_WRITE = 3'b001, HST_READ = 3'b011,
    HST_CSR_LO = 3'b010, HST_CSR_HI = 3'b110, HST_STEP = 3'b111
  } lcdsm_hst_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic oe_n;
    logic we_n;
  } lcdsm_vram_t;
  typedef struct packed {
    logic shift_clock_out;
    logic line_latch_pulse;
    logic frame_alternation_out;
  } lcdsm_lcd_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [3:0] row;
    logic lower;
    logic graphics;
    logic two_bytes;
  } lcdsm_scan_t;
  typedef struct packed {
    lcdsm_hst_t hst;
    logic [15:0] cursor;
    logic [7:0] step;
    logic pend;
    logic pend_rd;
    logic slot;
    logic [7:0] wbuf;
    logic [7:0] rbuf;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [3:0] phase;
    logic [7:0] char_cnt;
    logic [3:0] row;
    logic [7:0] rline;
    logic panel;
    logic [15:0] ls_up;
    logic [15:0] ls_lo;
    logic [7:0] cr;
    logic [7:0] tcr;
    logic [7:0] pitch;
    logic [7:0] lines;
    logic [15:0] sad_up;
    logic [15:0] sad_lo;
    logic graphics;
    logic dual;
    logic [3:0] fy;
    logic [3:0] fx;
    logic ack;
    logic [31:0] dat;
    lcdsm_vram_t vram;
    lcdsm_lcd_t lcd;
    lcdsm_scan_t scan;
  } lcdsm_state_t;

  function automatic lcdsm_state_t lcdsm_rst_f();
    lcdsm_state_t s;
    s = '0;
    s.step = STEP_RST;
    s.cr = CHAR_CNT_RST;
    s.tcr = TOTAL_CNT_RST;
    s.pitch = PITCH_RST;
    s.lines = LINES_RST;
    s.fy = FY_RST;
    s.fx = FX_RST;
    s.vram.oe_n = 1'b1;
    s.vram.we_n = 1'b1;
    return s;
  endfunction : lcdsm_rst_f

  localparam lcdsm_state_t ST_RST = lcdsm_rst_f();
endpackage : lcdsm_pkg

// *** verif/lcdsm_vram_model.sv ***
// lcdsm_vram_model: asynchronous display memory facing the scan block
`timescale 1ns/10ps
`default_nettype none
module lcdsm_vram_model
  import lcdsm_pkg::*;
(
  // memory port driven by the block
  input wire lcdsm_vram_t vram_i,
  // read data back to the block
  output logic [7:0] rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // preload a pattern that the bench recomputes from the address
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
    end
    last_r = 8'h00;
  end
  // write lands at the end of the strobe, address is held through it
  always @(posedge vram_i.we_n) begin
    mem[vram_i.addr] <= vram_i.wdata;
  end
  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  // remember what was driven when the output enable is released
  always @(posedge vram_i.oe_n) begin
    last_r = mem[vram_i.addr];
  end
  // no pull resistor: a released bus must not look like valid data
  always @* begin
    if (vram_i.oe_n === 1'b0) begin
      rdata = mem[vram_i.addr];
    end else begin
      rdata = ~last_r;
    end
  end
endmodule : lcdsm_vram_model
`default_nettype wire

// *** verif/lcd_scan_and_memory_access_bench.sv ***
// bench: register bus tests of the scan and memory access block
`timescale 1ns/10ps
`default_nettype none
module lcd_scan_and_memory_access_bench;
  import lcdsm_pkg::*;
  logic core_clk, reset_n, wb_cyc, wb_stb, wb_we, wb_ack, retrace;
  logic [7:0] wb_adr, vram_rdata;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, rd_v;
  lcdsm_vram_t vram, prev_addr;
  lcdsm_lcd_t lcd;
  lcdsm_scan_t scan;
  int mismatches, total_checks, cyc_n, last_chg, n, m;
  logic [15:0] a;
  logic [12:0] cap_q[$];
  int tim_q[$];

  lcdsm_top uut (.core_clk(core_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .vram_o(vram),
    .vram_rdata_i(vram_rdata), .lcd_o(lcd), .scan_o(scan),
    .retrace_flag_bit(retrace));
  lcdsm_vram_model mdl (.vram_i(vram), .rdata(vram_rdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one classic cycle; entered just after a rising edge
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int k;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 200);
    chk(32'(k < 200), 32'h1);
    rd_v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  // start capturing scan bytes at a frame restart
  task frame_sync;
    logic f;
    int k;
    f = lcd.frame_alternation_out;
    k = 0;
    while (lcd.frame_alternation_out === f && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    cap_q.delete();
    tim_q.delete();
    while (cap_q.size() < 12 && k < 6000) begin
      @(posedge core_clk);
      k++;
    end
  endtask : frame_sync
  task tally_and_finish;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ---------------------------------------------------------------
  // clock, monitors and watchdog
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // scan capture and memory address pacing, both at the sampling edge
  always @(posedge core_clk) begin
    cyc_n++;
    if (scan.valid === 1'b1) begin
      cap_q.push_back({scan.two_bytes, scan.row, scan.data});
      tim_q.push_back(cyc_n);
    end
    if (reset_n !== 1'b1) begin
      last_chg = cyc_n - 3;
    end else if (vram.addr !== prev_addr.addr) begin
      chk(32'(cyc_n - last_chg >= 3), 32'h1);
      last_chg = cyc_n;
    end
    prev_addr = vram;
  end
  // hang guard, far beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {reset_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
    wb_sel = 4'hf;
    {mismatches, total_checks, cyc_n, last_chg} = '0;
    repeat (4) @(posedge core_clk);
    chk(lcd, 0);
    reset_n <= 1'b1; // held four cycles, a scaled stand
    @(posedge core_clk);
    wb(0, ADR_CHAR_CNT, 0);
    chk(rd_v, 32'h27);
    wb(0, ADR_LINES, 0);
    chk(rd_v, 32'hef);
    wb(0, 8'h30, 0);
    chk(rd_v, 0);
    // graphics: 4 reads per line, total 7 cycles, pitch 8, two lines
    wb(1, ADR_CHAR_CNT, 3);
    wb(1, ADR_TOTAL_CNT, 6);
    wb(1, ADR_PITCH, 8);
    wb(1, ADR_LINES, 1);
    wb(1, ADR_START_UP, 32'h0100);
    wb(1, ADR_MODE, 32'h0701);
    frame_sync();
    for (int i = 0; i < 8; i++) begin
      a = 16'h0100 + 16'((i / 4) * 8 + i % 4);
      chk(cap_q[i][7:0], a[7:0] ^ a[15:8] ^ 8'h5a);
    end
    chk(tim_q[1] - tim_q[0], 9);
    chk(tim_q[4] - tim_q[3], 36);
    n = 0;
    m = 0;
    repeat (126) begin
      @(posedge core_clk);
      n += int'(retrace === 1'b1);
      m += int'(lcd.shift_clock_out === 1'b1);
    end
    chk(n, 54);
    chk(m, 56);
    // text, two glyph rows, field ten pixels wide
    wb(1, ADR_LINES, 3);
    wb(1, ADR_MODE, 32'h0910);
    frame_sync();
    for (int i = 0; i < 12; i++) begin
      a = 16'h0100 + 16'((i / 8) * 8 + i % 4);
      chk(cap_q[i][7:0], a[7:0] ^ a[15:8] ^ 8'h5a);
      chk(cap_q[i][12:8], 5'h10 | 5'((i / 4) % 2));
    end
    // two panels: upper line then the same line of the lower panel
    wb(1, ADR_START_LO, 32'h0300);
    wb(1, ADR_MODE, 32'h0003);
    frame_sync();
    for (int i = 0; i < 12; i++) begin
      a = (((i / 4) % 2) ? 16'h0300 : 16'h0100) + 16'((i / 8) * 8 + i % 4);
      chk(cap_q[i][7:0], a[7:0] ^ a[15:8] ^ 8'h5a);
    end
    // stream starts at a latch pulse falling edge
    @(negedge lcd.line_latch_pulse);
    @(posedge core_clk);
    // streamed write at cursor 0x0200 with step 2, command sent once
    wb(1, ADR_PORT_CMD, CMD_CURSOR_SET);
    wb(1, ADR_PORT_DATA, 0);
    wb(1, ADR_PORT_DATA, 2);
    wb(1, ADR_PORT_CMD, CMD_CURSOR_STEP);
    wb(1, ADR_PORT_DATA, 2);
    wb(1, ADR_PORT_CMD, CMD_MEM_WRITE);
    for (int i = 0; i < 3; i++) wb(1, ADR_PORT_DATA, 32'ha1 + i);
    wb(0, ADR_PORT_CMD, 0);
    chk(rd_v[15:0], 16'h0206);
    for (int i = 0; i < 3; i++) begin
      chk(mdl.mem[16'h0200 + 2 * i], 8'ha1 + i);
    end
    // buffered read back, each read waits for its answer
    wb(1, ADR_PORT_CMD, CMD_CURSOR_SET);
    wb(1, ADR_PORT_DATA, 0);
    wb(1, ADR_PORT_DATA, 2);
    wb(1, ADR_PORT_CMD, CMD_MEM_READ);
    for (int i = 0; i < 3; i++) begin
      wb(0, ADR_PORT_CMD, 0);
      chk(rd_v[7:0], 8'ha1 + i);
    end
    // second reset in mid-scan halts the drive outputs
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(lcd, 0);
    chk(wb_ack, 0);
    reset_n <= 1'b1;
    @(posedge core_clk);
    wb(0, ADR_CHAR_CNT, 0);
    chk(rd_v, 32'h27);
    tally_and_finish();
  end
endmodule : lcd_scan_and_memory_access_bench
`default_nettype wire
